// *** verilog/smw_pkg.sv ***
// constants, types and helpers shared by both ends of the sleep/wake link
//
// How it works
// - mode field code 110 enters sleep
// - only a new mode code leaves sleep
// - sleep powers down all but wake detection
// - host clears bias/reference bits for full power-down
// - chip select low wakes the serial port
// - master mode, no select: data falling edge wakes
// - host drives data high two clocks, then low
// - host may hold data high, then pull low
// - slave mode, no select: instruction byte wakes
// - non-sleep code runs brief power-up sequence first
// - one conversion, then new mode takes effect
// - data-ready held high two conversions after waking
// - host re-enables bias/reference itself; no auto-restore
// - code 000 is normal conversion with data-ready
package smw_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // operating mode field
    typedef logic [2:0] smw_mode_t;
    localparam smw_mode_t MODE_NORMAL = 3'h0;
    localparam smw_mode_t MODE_SLEEP = 3'h6;

    // command byte layout, at register address CMD_ADDR
    localparam logic [3:0] CMD_ADDR = 4'h4;
    localparam int MODE_LSB = 5;
    localparam int MODE_MSB = 7;
    localparam int BIAS_BIT = 1;
    localparam int REF_BIT = 0;
    // reference on, bias off, normal mode
    localparam logic [7:0] CMD_RST = 8'h01;
    localparam logic [7:0] REG_RST = 8'h00;

    // instruction byte: bit 7 is read/write, bits 3:0 the address
    localparam int INSTR_RW_BIT = 7;
    localparam logic [3:0] INSTR_WRITE_HI = 4'h0;
    localparam int FRAME_BITS = 16;
    localparam int REG_COUNT = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;
    // wake high time: two input clock periods
    localparam int WAKE_HIGH_NS = 2 * CLK_PERIOD_NS;
    localparam int WAKE_HIGH_CYC =
        (WAKE_HIGH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CONV_CYC_DEF = 64;
    localparam int PWRUP_CYC_DEF = 8;
    localparam int READY_LOW_CYC = 4;
    localparam int SCLK_HALF_DEF = 2;
    localparam int GAP_CYC_DEF = 4;
    localparam int CNT_W = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // state machines
    typedef enum logic [4:0] {
        DS_RUN = 5'h01,
        DS_SLEEP = 5'h02,
        DS_PWRUP = 5'h04,
        DS_CONV1 = 5'h08,
        DS_CONV2 = 5'h10
    } smw_dev_st_t;

    typedef enum logic [4:0] {
        HS_IDLE = 5'h01,
        HS_WAKEHI = 5'h02,
        HS_WAKELO = 5'h04,
        HS_SHIFT = 5'h08,
        HS_GAP = 5'h10
    } smw_host_st_t;

    function automatic smw_mode_t modeOf(input logic [7:0] cmdByte);
        return cmdByte[MODE_MSB:MODE_LSB];
    endfunction

    function automatic logic [7:0] writeInstr(input logic [3:0] addr);
        return {INSTR_WRITE_HI, addr};
    endfunction

endpackage

// *** verilog/smw_link_if.sv ***
// serial link between the converter control end and the host end
`timescale 1ns/1ps
interface smw_link_if;
    logic csN;
    logic sclk;
    logic sdioHostOut;
    logic sdioHostOe;
    logic sdioDevOut;
    logic sdioDevOe;
    logic sdio;
    logic dataReadyN;

    // a pull-up holds the data line high when nobody drives it
    assign sdio = sdioHostOe ? sdioHostOut : (sdioDevOe ? sdioDevOut : 1'b1);

    modport dev (
        input csN,
        input sclk,
        input sdio,
        output sdioDevOut,
        output sdioDevOe,
        output dataReadyN
    );

    modport host (
        output csN,
        output sclk,
        output sdioHostOut,
        output sdioHostOe,
        input sdio,
        input dataReadyN
    );
endinterface

// *** verilog/smw_device.sv ***
// converter control end: serial write port, sleep entry, wake and power-up sequencing
`timescale 1ns/1ps
module smw_device #(
    parameter int CONV_CYC = smw_pkg::CONV_CYC_DEF,
    parameter int PWRUP_CYC = smw_pkg::PWRUP_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    smw_link_if.dev link,
    input wire logic useCs,
    input wire logic masterMode,
    output logic biasEnable,
    output logic refEnable,
    output logic analogOn,
    output smw_pkg::smw_mode_t modeActive
);
    import smw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    smw_dev_st_t state_r;
    smw_dev_st_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic sclkPrev_r;
    logic sdioPrev_r;
    logic awake_r;
    logic [FRAME_BITS-2:0] shift_r;
    logic [4:0] bitCnt_r;
    logic [7:0] regs_r [0:REG_COUNT-1];
    smw_mode_t modeEff_r;
    smw_mode_t modePend_r;
    logic dataReadyN_r;

    logic sclkRise;
    logic sdioFall;
    logic rxEn;
    logic frameReset;
    logic wordDone;
    logic [FRAME_BITS-1:0] word;
    logic regWr;
    logic modeWr;
    smw_mode_t newMode;
    logic cntZero;
    logic enterSleep;

    ////////////////////////////////////////////////////////////////////////////////
    // serial receive
    assign sclkRise = link.sclk & ~sclkPrev_r;
    assign sdioFall = ~link.sdio & sdioPrev_r;
    // asleep the shifter is dead unless a wake was seen; slave mode without
    // select keeps it alive because the instruction byte itself is the wake
    assign rxEn = (state_r != DS_SLEEP) | awake_r | (~useCs & ~masterMode);
    assign frameReset = useCs & link.csN;
    assign wordDone = sclkRise & rxEn & ~frameReset
        & (bitCnt_r == 5'(FRAME_BITS - 1));
    assign word = {shift_r, link.sdio};
    assign regWr = wordDone & ~word[8 + INSTR_RW_BIT];
    assign modeWr = regWr & (word[11:8] == CMD_ADDR);
    assign newMode = modeOf(word[7:0]);

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sclkPrev_r <= 1'b0;
            sdioPrev_r <= 1'b1;
        end
        else
        begin
            sclkPrev_r <= link.sclk;
            sdioPrev_r <= link.sdio;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bitCnt_r <= 5'h00;
            shift_r <= '0;
        end
        else if (frameReset || !rxEn)
        begin
            bitCnt_r <= 5'h00;
        end
        else if (sclkRise)
        begin
            shift_r <= word[FRAME_BITS-2:0];
            bitCnt_r <= wordDone ? 5'h00 : bitCnt_r + 5'h01;
        end
    end

    // contents are never touched by sleep or wake
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < REG_COUNT; i++)
            begin
                regs_r[i] <= (4'(i) == CMD_ADDR) ? CMD_RST : REG_RST;
            end
        end
        else if (regWr)
        begin
            regs_r[word[11:8]] <= word[7:0];
        end
    end

    // bias and reference follow their bits only; nothing restores them
    assign biasEnable = regs_r[CMD_ADDR][BIAS_BIT];
    assign refEnable = regs_r[CMD_ADDR][REF_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // wake detection while asleep
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            awake_r <= 1'b0;
        end
        else if (enterSleep)
        begin
            awake_r <= 1'b0;
        end
        else if (state_r == DS_SLEEP)
        begin
            if (useCs && !link.csN)
            begin
                awake_r <= 1'b1;
            end
            else if (!useCs && masterMode && sdioFall)
            begin
                awake_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencing
    assign cntZero = (cnt_r == '0);
    assign enterSleep = (state_nxt == DS_SLEEP) && (state_r != DS_SLEEP);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            DS_RUN, DS_CONV2:
            begin
                if (modeWr && newMode == MODE_SLEEP)
                begin
                    state_nxt = DS_SLEEP;
                end
                else if (state_r == DS_CONV2 && cntZero)
                begin
                    state_nxt = DS_RUN;
                end
            end
            DS_SLEEP:
            begin
                if (modeWr && newMode != MODE_SLEEP)
                begin
                    state_nxt = DS_PWRUP;
                end
            end
            DS_PWRUP:
            begin
                if (cntZero)
                begin
                    state_nxt = DS_CONV1;
                end
            end
            DS_CONV1:
            begin
                if (cntZero)
                begin
                    state_nxt = (modePend_r == MODE_SLEEP) ? DS_SLEEP : DS_CONV2;
                end
            end
            default:
            begin
                state_nxt = DS_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= DS_RUN;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // one counter serves power-up and conversion timing; cleared to zero and held there asleep
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= CNT_W'(CONV_CYC - 1);
        end
        else if (state_nxt == DS_SLEEP)
        begin
            cnt_r <= '0;
        end
        else if (state_nxt == DS_PWRUP && state_r != DS_PWRUP)
        begin
            cnt_r <= CNT_W'(PWRUP_CYC - 1);
        end
        else if (cntZero || state_nxt != state_r)
        begin
            cnt_r <= CNT_W'(CONV_CYC - 1);
        end
        else
        begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // mode written while waking is held until the first conversion ends
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            modePend_r <= MODE_NORMAL;
            modeEff_r <= MODE_NORMAL;
        end
        else
        begin
            if (modeWr && (state_r == DS_SLEEP || state_r == DS_PWRUP
                || state_r == DS_CONV1))
            begin
                modePend_r <= newMode;
            end
            if (enterSleep)
            begin
                modeEff_r <= MODE_SLEEP;
            end
            else if (state_r == DS_CONV1 && cntZero)
            begin
                modeEff_r <= modePend_r;
            end
            else if (modeWr && (state_r == DS_RUN || state_r == DS_CONV2))
            begin
                modeEff_r <= newMode;
            end
        end
    end

    assign modeActive = modeEff_r;
    assign analogOn = (state_r != DS_SLEEP);

    ////////////////////////////////////////////////////////////////////////////////
    // data ready: low for a short window after each conversion in normal mode;
    // every state other than run keeps it high, which covers both wake cycles
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dataReadyN_r <= 1'b1;
        end
        else if (state_r != DS_RUN)
        begin
            dataReadyN_r <= 1'b1;
        end
        else if (cntZero && modeEff_r == MODE_NORMAL)
        begin
            dataReadyN_r <= 1'b0;
        end
        else if (cnt_r == CNT_W'(CONV_CYC - 1 - READY_LOW_CYC))
        begin
            dataReadyN_r <= 1'b1;
        end
    end

    assign link.dataReadyN = dataReadyN_r;
    // reads are not served, so this end never drives the data line
    assign link.sdioDevOut = 1'b0;
    assign link.sdioDevOe = 1'b0;

endmodule // smw_device

// *** verilog/smw_host.sv ***
// host end: serial register writes with the wake procedure for a sleeping converter
`timescale 1ns/1ps
module smw_host #(
    parameter int SCLK_HALF = smw_pkg::SCLK_HALF_DEF,
    parameter int GAP_CYC = smw_pkg::GAP_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    smw_link_if.host link,
    input wire logic useCs,
    input wire logic masterMode,
    input wire logic holdHigh,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic [3:0] reqAddr,
    input wire logic [7:0] reqData,
    output logic asleep
);
    import smw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    smw_host_st_t state_r;
    logic [FRAME_BITS-1:0] frame_r;
    logic [3:0] addr_r;
    logic [7:0] data_r;
    logic [4:0] bitIdx_r;
    logic [CNT_W-1:0] cnt_r;
    logic asleep_r;
    logic needEdge;
    logic holdLine;

    assign reqReady = (state_r == HS_IDLE);
    assign needEdge = asleep_r & ~useCs & masterMode;
    assign holdLine = needEdge & holdHigh;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= HS_IDLE;
            frame_r <= '0;
            addr_r <= 4'h0;
            data_r <= 8'h00;
            bitIdx_r <= 5'h00;
            cnt_r <= '0;
        end
        else
        begin
            case (state_r)
                HS_IDLE:
                begin
                    if (reqValid)
                    begin
                        frame_r <= {writeInstr(reqAddr), reqData};
                        addr_r <= reqAddr;
                        data_r <= reqData;
                        bitIdx_r <= 5'h00;
                        if (holdLine)
                        begin
                            state_r <= HS_WAKELO;
                        end
                        else if (needEdge)
                        begin
                            state_r <= HS_WAKEHI;
                            cnt_r <= CNT_W'(WAKE_HIGH_CYC - 1);
                        end
                        else
                        begin
                            state_r <= HS_SHIFT;
                            cnt_r <= '0;
                        end
                    end
                end
                HS_WAKEHI:
                begin
                    if (cnt_r == '0)
                    begin
                        state_r <= HS_WAKELO;
                    end
                    else
                    begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                HS_WAKELO:
                begin
                    state_r <= HS_SHIFT;
                    cnt_r <= '0;
                end
                HS_SHIFT:
                begin
                    if (cnt_r == CNT_W'(2 * SCLK_HALF - 1))
                    begin
                        cnt_r <= '0;
                        frame_r <= {frame_r[FRAME_BITS-2:0], 1'b0};
                        if (bitIdx_r == 5'(FRAME_BITS - 1))
                        begin
                            state_r <= HS_GAP;
                            cnt_r <= CNT_W'(GAP_CYC - 1);
                        end
                        else
                        begin
                            bitIdx_r <= bitIdx_r + 5'h01;
                        end
                    end
                    else
                    begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                HS_GAP:
                begin
                    if (cnt_r == '0)
                    begin
                        state_r <= HS_IDLE;
                    end
                    else
                    begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default:
                begin
                    state_r <= HS_IDLE;
                end
            endcase
        end
    end

    // tracks what the converter was last told, so the next write wakes it
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            asleep_r <= 1'b0;
        end
        else if (state_r == HS_SHIFT && cnt_r == CNT_W'(2 * SCLK_HALF - 1)
            && bitIdx_r == 5'(FRAME_BITS - 1) && addr_r == CMD_ADDR)
        begin
            asleep_r <= (modeOf(data_r) == MODE_SLEEP);
        end
    end

    assign asleep = asleep_r;

    ////////////////////////////////////////////////////////////////////////////////
    // pins: data set up while the clock is low, sampled on its rise
    assign link.csN = useCs ? (state_r != HS_SHIFT) : 1'b0;
    assign link.sclk = (state_r == HS_SHIFT) && (cnt_r >= CNT_W'(SCLK_HALF));
    always_comb
    begin
        link.sdioHostOe = 1'b0;
        link.sdioHostOut = 1'b1;
        case (state_r)
            HS_SHIFT:
            begin
                link.sdioHostOe = 1'b1;
                link.sdioHostOut = frame_r[FRAME_BITS-1];
            end
            HS_WAKEHI:
            begin
                link.sdioHostOe = 1'b1;
            end
            HS_WAKELO:
            begin
                link.sdioHostOe = 1'b1;
                link.sdioHostOut = 1'b0;
            end
            default:
            begin
                link.sdioHostOe = holdLine;
            end
        endcase
    end

endmodule // smw_host

// *** dv/smw_link_properties.sv ***
// link checker: sleep entry, wake and data-ready timing seen on the serial link
`timescale 1ns/1ps
module smw_link_properties #(
    parameter int CONV_CYC = smw_pkg::CONV_CYC_DEF,
    parameter int PWRUP_CYC = smw_pkg::PWRUP_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdioHostOut,
    input wire logic sdioHostOe,
    input wire logic sdioDevOut,
    input wire logic sdioDevOe,
    input wire logic sdio,
    input wire logic dataReadyN
);
    import smw_pkg::*;
    // first low comes a conversion after the two held ones; margin covers sampling skew
    localparam int QUIET = PWRUP_CYC + 3 * CONV_CYC - 2;
    localparam int LOW_MAX = PWRUP_CYC + 3 * CONV_CYC + 4;
    logic sclk_r;
    logic [3:0] bitCnt_r;
    logic [14:0] shift_r;
    logic slept_r;
    logic [7:0] slpCnt_r;
    logic [15:0] wakeCnt_r;
    logic [15:0] word;
    logic frameEnd, cmdWrite, sleepEvt, wakeEvt, wakeNorm;
    assign word = {shift_r, sdio};
    assign frameEnd = sclk & ~sclk_r & (bitCnt_r == 4'hf);
    assign cmdWrite = frameEnd & (word[15:8] == {4'h0, CMD_ADDR});
    assign sleepEvt = cmdWrite & (word[7:5] == MODE_SLEEP);
    assign wakeEvt = cmdWrite & slept_r & (word[7:5] != MODE_SLEEP);
    assign wakeNorm = wakeEvt & (word[7:5] == MODE_NORMAL);

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sclk_r <= 1'b0;
            bitCnt_r <= 4'h0;
            shift_r <= 15'h0;
        end
        else
        begin
            sclk_r <= sclk;
            if (csN)
                bitCnt_r <= 4'h0;
            else if (sclk & ~sclk_r)
            begin
                bitCnt_r <= bitCnt_r + 4'h1;
                shift_r <= word[14:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            slept_r <= 1'b0;
        else
            slept_r <= sleepEvt | (slept_r & ~wakeEvt);
    end

    // saturates so a long sleep never wraps back under the threshold
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            slpCnt_r <= 8'h00;
        else if (slept_r & ~wakeEvt)
            slpCnt_r <= slpCnt_r + {7'h00, slpCnt_r != 8'hff};
        else
            slpCnt_r <= 8'h00;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            wakeCnt_r <= 16'h0000;
        else if (wakeEvt)
            wakeCnt_r <= 16'h0001;
        else if (wakeCnt_r != 16'h0000 && wakeCnt_r < 16'(LOW_MAX))
            wakeCnt_r <= wakeCnt_r + 16'h0001;
        else
            wakeCnt_r <= 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    property p_asleepQuiet;
        slpCnt_r > 8'h04 |-> dataReadyN;
    endproperty
    a_asleepQuiet: assert property (p_asleepQuiet)
        else $error("data ready low while asleep");
    property p_wakeQuiet;
        wakeCnt_r != 16'h0000 && wakeCnt_r < 16'(QUIET) |-> dataReadyN;
    endproperty
    a_wakeQuiet: assert property (p_wakeQuiet)
        else $error("data ready low too soon after wake");
    property p_wakeNormal;
        wakeNorm |-> ##[QUIET:LOW_MAX] !dataReadyN;
    endproperty
    a_wakeNormal: assert property (p_wakeNormal)
        else $error("no data ready after wake into normal mode");
    property p_wakeEdge;
        $fell(sdio) && slept_r && !sclk |-> $past(sdio, 2);
    endproperty
    a_wakeEdge: assert property (p_wakeEdge)
        else $error("wake edge without two high cycles");
    property p_sclkSelected;
        $rose(sclk) |-> !csN ##1 !csN;
    endproperty
    a_sclkSelected: assert property (p_sclkSelected)
        else $error("serial clock while deselected");
    property p_idleNoClock;
        csN |-> !sclk;
    endproperty
    a_idleNoClock: assert property (p_idleNoClock)
        else $error("serial clock high while select high");
    property p_sclkHalf;
        $rose(sclk) |-> sclk [*2] ##1 !sclk;
    endproperty
    a_sclkHalf: assert property (p_sclkHalf)
        else $error("serial clock high time wrong");
    property p_devQuiet;
        !sdioDevOe;
    endproperty
    a_devQuiet: assert property (p_devQuiet)
        else $error("device drives data line");

    c_sleep: cover property (sleepEvt);
    c_wakeNorm: cover property (wakeNorm);
    c_wakeOther: cover property (wakeEvt && !wakeNorm);
endmodule // smw_link_properties

// *** dv/sleep_mode_wake_control_test.sv ***
// self-checking bench: host and converter ends joined by the serial link
`timescale 1ns/1ps
module sleep_mode_wake_control_test;
    import smw_pkg::*;
    localparam int CONV = 16;
    localparam int PWRUP = 2;
    localparam int WATCHDOG_CYC = 8 * 600 + 2000;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic useCs = 1'b1;
    logic masterMode = 1'b0;
    logic holdHigh = 1'b0;
    logic reqValid = 1'b0;
    logic [3:0] reqAddr = 4'h0;
    logic [7:0] reqData = 8'h00;
    logic reqReady, asleep, biasEnable, refEnable, analogOn;
    smw_mode_t modeActive;
    integer seed = 32'hc48fd1f6;
    int failures = 0;
    int n_tests = 0;
    smw_link_if link();

    always #25 clk_sys = ~clk_sys;

    smw_host u_smw_host (.clk_sys(clk_sys), .arst_n(arst_n), .link(link), .useCs(useCs),
        .masterMode(masterMode), .holdHigh(holdHigh), .reqValid(reqValid),
        .reqReady(reqReady), .reqAddr(reqAddr), .reqData(reqData), .asleep(asleep));
    smw_device #(.CONV_CYC(CONV), .PWRUP_CYC(PWRUP)) u_smw_device (.clk_sys(clk_sys),
        .arst_n(arst_n), .link(link), .useCs(useCs), .masterMode(masterMode),
        .biasEnable(biasEnable), .refEnable(refEnable), .analogOn(analogOn),
        .modeActive(modeActive));
    smw_link_properties #(.CONV_CYC(CONV), .PWRUP_CYC(PWRUP)) u_smw_link_properties (
        .clk_sys(clk_sys), .arst_n(arst_n), .csN(link.csN), .sclk(link.sclk),
        .sdioHostOut(link.sdioHostOut), .sdioHostOe(link.sdioHostOe),
        .sdioDevOut(link.sdioDevOut), .sdioDevOe(link.sdioDevOe), .sdio(link.sdio),
        .dataReadyN(link.dataReadyN));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] cmdOf(input smw_mode_t m, input logic [4:0] low);
        return {m, low};
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // assumes the host is idle, so the request is taken at the first edge it is seen
    task automatic hostWrite(input logic [3:0] addr, input logic [7:0] data);
        int guard;
        @(posedge clk_sys);
        reqValid <= 1'b1;
        reqAddr <= addr;
        reqData <= data;
        @(posedge clk_sys);
        reqValid <= 1'b0;
        guard = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            guard++;
        end
        while (reqReady !== 1'b1 && guard < 300);
        check("write finished", 8'(reqReady), 8'h01);
        #1;
    endtask

    task automatic waitLow(input int limit);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < limit && !seen; i++)
        begin
            @(posedge clk_sys);
            #1;
            if (link.dataReadyN === 1'b0)
                seen = 1'b1;
        end
        check("data ready low", 8'(seen), 8'h01);
        #1;
    endtask

    task automatic sleepWake(input int idx);
        logic [31:0] r;
        smw_mode_t m;
        logic [7:0] slp;
        logic [7:0] wak;
        r = $random(seed);
        m = (idx % 2 == 0 || r[23:22] == 2'b11) ? MODE_NORMAL : smw_mode_t'(r[23:21]);
        slp = cmdOf(MODE_SLEEP, r[4:0]);
        wak = cmdOf(m, r[20:16]);
        hostWrite(CMD_ADDR, cmdOf(MODE_NORMAL, r[28:24]));
        check("mode awake", 8'(modeActive), 8'(MODE_NORMAL));
        cycles(int'(r[7:5]));
        hostWrite(CMD_ADDR, slp);
        check("mode asleep", 8'(modeActive), 8'(MODE_SLEEP));
        check("host asleep", 8'(asleep), 8'h01);
        cycles(int'(r[12:8]));
        check("analog asleep", 8'(analogOn), 8'h00);
        check("ready asleep", 8'(link.dataReadyN), 8'h01);
        check("bias asleep", 8'(biasEnable), 8'(slp[BIAS_BIT]));
        check("ref kept", 8'(refEnable), 8'(slp[REF_BIT]));
        check("select idle", 8'(link.csN), 8'(useCs));
        check("line high", 8'(link.sdio), 8'h01);
        if (holdHigh)
            check("line held", 8'(link.sdioHostOe), 8'h01);
        hostWrite(CMD_ADDR, wak);
        check("host awake", 8'(asleep), 8'h00);
        check("analog up", 8'(analogOn), 8'h01);
        check("mode pending", 8'(modeActive), 8'(MODE_SLEEP));
        check("bias as written", 8'(biasEnable), 8'(wak[BIAS_BIT]));
        cycles(PWRUP + CONV);
        check("new mode", 8'(modeActive), 8'(m));
        check("ready held", 8'(link.dataReadyN), 8'h01);
        if (m == MODE_NORMAL)
            waitLow(2 * CONV + 8);
        $display("test %0d done", idx);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        // cfg 0: select used; 1: master wake pulse; 2: master held high; 3: slave
        for (int cfg = 0; cfg < 4; cfg++)
        begin
            @(posedge clk_sys);
            useCs <= (cfg == 0);
            masterMode <= (cfg != 3);
            holdHigh <= (cfg == 2);
            arst_n <= 1'b0;
            repeat (2) @(posedge clk_sys);
            arst_n <= 1'b1;
            cycles(1);
            check("mode reset", 8'(modeActive), 8'(MODE_NORMAL));
            check("ref reset", 8'(refEnable), 8'h01);
            check("bias reset", 8'(biasEnable), 8'h00);
            waitLow(3 * CONV + 8);
            for (int rep = 0; rep < 2; rep++)
                sleepWake(cfg * 2 + rep);
        end
        close_out();
    end

    initial
    begin
        repeat (WATCHDOG_CYC) @(posedge clk_sys);
        failures++;
        $display("watchdog expired");
        close_out();
    end
endmodule // sleep_mode_wake_control_test
